// >>> soc_pkg.sv
// Summary of operation
// - moving reference boundary shifts: safety outputs forced OFF
// - access mode: penetration or reference distance change forces safety outputs OFF
// - sequence check on: area change outside permitted successors forces outputs OFF
// - up to 31 successors per area; an empty list flags a configuration error
// - sequence check off: any area change is accepted without fault
// - per-channel OFF 60..2010 ms and ON 270..2010 ms delays, 30 ms steps
// - area change adds at most one extra 30 ms scan cycle of delay
// - slave outputs unused: default delays 120 ms OFF, 300 ms ON
// - all slave outputs used: default delays 60 ms OFF, 300 ms ON
// - eight non-safety functions share four terminals, selected by configuration
// - first alert output OFF while an obstacle is in first warning zone
// - second alert output OFF while an obstacle is in second warning zone
// - zone A muted or overridden: suppression indicator A ON, display 37
// - zone B muted or overridden: suppression indicator B ON, display 38
// - both zones muted or overridden: display 39 instead
// - rearm request A ON when zone A can accept a reset
// - rearm request B ON when zone B can accept a reset
// - reset held beyond 30 s is taken as a hardware malfunction
package soc_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_HZ = 20000000;
    localparam int MS_CYCLES = CLK_HZ / 1000;
    localparam int SCAN_MS = 30;
    localparam int OFF_MIN_MS = 60;
    localparam int OFF_MAX_MS = 2010;
    localparam int ON_MIN_MS = 270;
    localparam int ON_MAX_MS = 2010;
    localparam int DEF_OFF_SOLO_MS = 120;
    localparam int DEF_OFF_SLAVE_MS = 60;
    localparam int DEF_ON_MS = 300;
    localparam int RESET_MIN_MS = 500;
    localparam int RESET_MAX_MS = 30000;

    typedef logic [6:0] soc_step_t;
    localparam soc_step_t OFF_MIN_STEP = soc_step_t'(OFF_MIN_MS / SCAN_MS);
    localparam soc_step_t OFF_MAX_STEP = soc_step_t'(OFF_MAX_MS / SCAN_MS);
    localparam soc_step_t ON_MIN_STEP = soc_step_t'(ON_MIN_MS / SCAN_MS);
    localparam soc_step_t ON_MAX_STEP = soc_step_t'(ON_MAX_MS / SCAN_MS);
    localparam soc_step_t DEF_OFF_SOLO_STEP = soc_step_t'(DEF_OFF_SOLO_MS / SCAN_MS);
    localparam soc_step_t DEF_OFF_SLAVE_STEP = soc_step_t'(DEF_OFF_SLAVE_MS / SCAN_MS);
    localparam soc_step_t DEF_ON_STEP = soc_step_t'(DEF_ON_MS / SCAN_MS);
    localparam logic [14:0] RESET_MIN_CNT = 15'(RESET_MIN_MS);
    localparam logic [14:0] RESET_MAX_CNT = 15'(RESET_MAX_MS);

    // ****************************************
    // areas and display
    // ****************************************
    localparam int AREA_W = 5;
    localparam int NUM_AREAS = 32;
    localparam logic [7:0] DISP_INIT = 8'h00;
    localparam logic [7:0] DISP_MUTE_A = 8'h25;
    localparam logic [7:0] DISP_MUTE_B = 8'h26;
    localparam logic [7:0] DISP_MUTE_AB = 8'h27;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_TERM = 4'h1;
    localparam logic [3:0] ADDR_DLY0 = 4'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h6;
    localparam logic [3:0] ADDR_DISP = 4'h7;
    localparam logic [3:0] ADDR_SEQ_IDX = 4'h8;
    localparam logic [3:0] ADDR_SEQ_DATA = 4'h9;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] TERM_RST = 32'h0000_0000;
    localparam logic [31:0] DLY_RST = 32'h0000_0A04;
    localparam int CTRL_REF_EN = 0;
    localparam int CTRL_ACCESS_EN = 1;
    localparam int CTRL_SEQ_EN = 2;
    localparam int CTRL_START_LOCK = 3;
    localparam int CTRL_MANUAL = 4;
    localparam int CTRL_SLAVES_USED = 5;
    localparam int CTRL_DLY_CUSTOM = 6;
    localparam int TERM_C_SEL = 0;
    localparam int TERM_D_SEL = 1;
    localparam int TERM_E_LSB = 2;
    localparam int TERM_F_LSB = 4;
    localparam int DLY_OFF_LSB = 0;
    localparam int DLY_ON_LSB = 8;
    localparam logic [1:0] MULTI_REARM = 2'h0;
    localparam logic [1:0] MULTI_MUTE = 2'h1;
    localparam logic [1:0] MULTI_AUX = 2'h2;
endpackage : soc_pkg

// >>> soc_succ_mem.sv
`timescale 1ns/1ps
module soc_succ_mem #(
    parameter int DEPTH = 32,
    parameter int WIDTH = 32
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic we,
    input wire logic [$clog2(DEPTH)-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    // ****************************************
    // successor table storage
    // ****************************************
    // write port, no reset on the array itself
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // registered read, one cycle latency
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= '0;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule : soc_succ_mem

// >>> soc_top.sv
`timescale 1ns/1ps
module soc_top #(
    parameter int MS_CYC = soc_pkg::MS_CYCLES
) (
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic [3:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic INIT_DONE,
    input wire logic ZONE_A_OBJ,
    input wire logic ZONE_B_OBJ,
    input wire logic WARN_A_OBJ,
    input wire logic WARN_B_OBJ,
    input wire logic REF_SHIFT,
    input wire logic ACCESS_PEN,
    input wire logic [4:0] AREA_SEL,
    input wire logic MUTE_A,
    input wire logic MUTE_B,
    input wire logic AUX_A,
    input wire logic AUX_B,
    input wire logic RESET_IN,
    output logic SAFETY_SWITCH_OUTPUT,
    output logic TERM_ALERT_A,
    output logic TERM_ALERT_B,
    output logic TERM_MULTI_A,
    output logic TERM_MULTI_B,
    output logic [7:0] DISPLAY_CODE
);
    // ****************************************
    // functions
    // ****************************************
    // limit a configured step count to its legal range
    function automatic soc_pkg::soc_step_t step_clamp(input soc_pkg::soc_step_t v,
        input soc_pkg::soc_step_t lo, input soc_pkg::soc_step_t hi);
        step_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : step_clamp

    // select the function of a shared rearm/mute/aux terminal
    function automatic logic multi_sel(input logic [1:0] sel, input logic rearm,
        input logic mute, input logic aux);
        multi_sel = (sel == soc_pkg::MULTI_REARM) ? rearm :
                    (sel == soc_pkg::MULTI_MUTE) ? mute :
                    (sel == soc_pkg::MULTI_AUX) ? aux : 1'b0;
    endfunction : multi_sel

    // ****************************************
    // declarations
    // ****************************************
    logic [31:0] ctrl_reg;
    logic [31:0] term_reg;
    logic [31:0] dly_reg [4];
    logic [4:0] seq_idx_reg;
    logic [24:0] ms_cnt_reg;
    logic [4:0] scan_cnt_reg;
    logic [4:0] area_reg;
    logic [1:0] rd_valid_reg;
    logic skip_reg;
    logic rst_sync1_reg;
    logic rst_sync2_reg;
    logic rst_prev_reg;
    logic [14:0] hold_ms_reg;
    logic hw_fault_reg;
    logic init_prev_reg;
    logic [1:0] lock_reg;
    logic [3:0] dly_out_reg;
    logic [3:0] dly_prev_reg;
    logic [6:0] cnt_reg [4];
    logic [31:0] rdata_reg;
    logic safe_a_reg;
    logic alert_a_reg;
    logic alert_b_reg;
    logic multi_a_reg;
    logic multi_b_reg;
    logic [7:0] disp_reg;
    logic [31:0] succ_rdata;

    // ****************************************
    // configuration decode
    // ****************************************
    wire ref_en = ctrl_reg[soc_pkg::CTRL_REF_EN];
    wire access_en = ctrl_reg[soc_pkg::CTRL_ACCESS_EN];
    wire seq_en = ctrl_reg[soc_pkg::CTRL_SEQ_EN];
    wire start_lock = ctrl_reg[soc_pkg::CTRL_START_LOCK];
    wire manual = ctrl_reg[soc_pkg::CTRL_MANUAL];
    wire slaves_used = ctrl_reg[soc_pkg::CTRL_SLAVES_USED];
    wire dly_custom = ctrl_reg[soc_pkg::CTRL_DLY_CUSTOM];
    wire wr_ctrl = WR && (ADDR == soc_pkg::ADDR_CTRL);
    wire wr_term = WR && (ADDR == soc_pkg::ADDR_TERM);
    wire wr_seq_idx = WR && (ADDR == soc_pkg::ADDR_SEQ_IDX);
    wire wr_seq_data = WR && (ADDR == soc_pkg::ADDR_SEQ_DATA);

    // ****************************************
    // register writes
    // ****************************************
    // software configuration registers
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            ctrl_reg <= soc_pkg::CTRL_RST;
            term_reg <= soc_pkg::TERM_RST;
            seq_idx_reg <= '0;
        end else begin
            if (wr_ctrl) ctrl_reg <= WDATA;
            if (wr_term) term_reg <= WDATA;
            if (wr_seq_idx) seq_idx_reg <= WDATA[4:0];
        end
    end

    // successor table, one word per area, bit n allows a move to area n
    soc_succ_mem #(.DEPTH(soc_pkg::NUM_AREAS), .WIDTH(32)) u_succ (
        .clk(CLK_SYS),
        .rst_b(RST_B),
        .we(wr_seq_data),
        .waddr(seq_idx_reg),
        .wdata(WDATA),
        .raddr(area_reg),
        .rdata(succ_rdata)
    );

    // ****************************************
    // millisecond and scan-cycle dividers
    // ****************************************
    wire ms_tick = (ms_cnt_reg == 25'(MS_CYC - 1));
    wire scan_tick = ms_tick && (scan_cnt_reg == 5'(soc_pkg::SCAN_MS - 1));

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            ms_cnt_reg <= '0;
            scan_cnt_reg <= '0;
        end else begin
            ms_cnt_reg <= ms_tick ? 25'h0000000 : ms_cnt_reg + 25'h0000001;
            if (ms_tick) scan_cnt_reg <= scan_tick ? 5'h00 : scan_cnt_reg + 5'h01;
        end
    end

    // ****************************************
    // area sequence check
    // ****************************************
    // own area bit is never a legal successor
    wire [31:0] succ_mask = succ_rdata & ~(32'h0000_0001 << area_reg);
    wire succ_ok = rd_valid_reg[1];
    wire area_chg = (AREA_SEL != area_reg) && succ_ok;
    wire seq_bad = seq_en && area_chg && !succ_mask[AREA_SEL];
    wire cfg_err = seq_en && succ_ok && (succ_mask == 32'h0000_0000);

    // area is taken once the successor word of the old area is valid
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            area_reg <= '0;
            rd_valid_reg <= 2'h0;
            skip_reg <= 1'b0;
        end else begin
            if (area_chg) area_reg <= AREA_SEL;
            rd_valid_reg <= area_chg ? 2'h0 : {rd_valid_reg[0], 1'b1};
            if (area_chg) begin
                skip_reg <= 1'b1;
            end else if (scan_tick) begin
                skip_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // response delay channels
    // ****************************************
    // channel 0/1 protection zones A/B, 2/3 warning zones A/B, 1 = clear
    wire [3:0] chan_ok = {~WARN_B_OBJ, ~WARN_A_OBJ, ~ZONE_B_OBJ, ~ZONE_A_OBJ};
    wire eval_tick = scan_tick && !skip_reg;
    wire soc_pkg::soc_step_t def_off = slaves_used ? soc_pkg::DEF_OFF_SLAVE_STEP :
                                       soc_pkg::DEF_OFF_SOLO_STEP;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_chan
            wire soc_pkg::soc_step_t off_steps = dly_custom ?
                step_clamp(dly_reg[gi][soc_pkg::DLY_OFF_LSB +: 7],
                    soc_pkg::OFF_MIN_STEP, soc_pkg::OFF_MAX_STEP) : def_off;
            wire soc_pkg::soc_step_t on_steps = dly_custom ?
                step_clamp(dly_reg[gi][soc_pkg::DLY_ON_LSB +: 7],
                    soc_pkg::ON_MIN_STEP, soc_pkg::ON_MAX_STEP) :
                soc_pkg::DEF_ON_STEP;
            wire soc_pkg::soc_step_t target = dly_out_reg[gi] ? off_steps : on_steps;

            // delay register for this channel
            always_ff @(posedge CLK_SYS or negedge RST_B) begin
                if (!RST_B) begin
                    dly_reg[gi] <= soc_pkg::DLY_RST;
                end else if (WR && (ADDR == soc_pkg::ADDR_DLY0 + 4'(gi))) begin
                    dly_reg[gi] <= WDATA;
                end
            end

            // output follows only after the condition held for target scans
            always_ff @(posedge CLK_SYS or negedge RST_B) begin
                if (!RST_B) begin
                    cnt_reg[gi] <= '0;
                    dly_out_reg[gi] <= 1'b0;
                end else if (chan_ok[gi] == dly_out_reg[gi]) begin
                    cnt_reg[gi] <= '0;
                end else if (eval_tick) begin
                    if (cnt_reg[gi] + 7'h01 >= target) begin
                        dly_out_reg[gi] <= chan_ok[gi];
                        cnt_reg[gi] <= '0;
                    end else begin
                        cnt_reg[gi] <= cnt_reg[gi] + 7'h01;
                    end
                end
            end
        end
    endgenerate

    // ****************************************
    // reset input qualification
    // ****************************************
    wire rst_fall = rst_prev_reg && !rst_sync2_reg;
    wire rearm_ok = rst_fall && (hold_ms_reg > soc_pkg::RESET_MIN_CNT) &&
                    (hold_ms_reg <= soc_pkg::RESET_MAX_CNT);

    // two-stage synchroniser and hold-time measurement in ms
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            rst_sync1_reg <= 1'b0;
            rst_sync2_reg <= 1'b0;
            rst_prev_reg <= 1'b0;
            hold_ms_reg <= '0;
            hw_fault_reg <= 1'b0;
        end else begin
            rst_sync1_reg <= RESET_IN;
            rst_sync2_reg <= rst_sync1_reg;
            rst_prev_reg <= rst_sync2_reg;
            if (!rst_sync2_reg) begin
                hold_ms_reg <= '0;
            end else if (ms_tick && (hold_ms_reg <= soc_pkg::RESET_MAX_CNT)) begin
                hold_ms_reg <= hold_ms_reg + 15'h0001;
            end
            if (hold_ms_reg > soc_pkg::RESET_MAX_CNT) hw_fault_reg <= 1'b1;
        end
    end

    // ****************************************
    // interlock and fault latch
    // ****************************************
    wire ref_evt = (ref_en && REF_SHIFT) ||
                   (access_en && (ACCESS_PEN || REF_SHIFT));
    wire fault_evt = ref_evt || seq_bad || cfg_err;
    wire init_rise = INIT_DONE && !init_prev_reg;
    wire [1:0] drop = dly_prev_reg[1:0] & ~dly_out_reg[1:0];
    wire [1:0] ready = lock_reg & chan_ok[1:0] &
                       {2{!fault_evt && !hw_fault_reg && INIT_DONE}};

    // set wins over the clear from a valid reset
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            lock_reg <= 2'h0;
            init_prev_reg <= 1'b0;
            dly_prev_reg <= 4'h0;
        end else begin
            init_prev_reg <= INIT_DONE;
            dly_prev_reg <= dly_out_reg;
            for (int z = 0; z < 2; z++) begin
                if (fault_evt || (init_rise && start_lock) || (manual && drop[z])) begin
                    lock_reg[z] <= 1'b1;
                end else if (rearm_ok && ready[z]) begin
                    lock_reg[z] <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // output composition
    // ****************************************
    wire [1:0] safe_on = dly_out_reg[1:0] & ~lock_reg &
                         {2{!fault_evt && !hw_fault_reg && INIT_DONE}};
    wire alert_a = dly_out_reg[2] && INIT_DONE;
    wire alert_b = dly_out_reg[3] && INIT_DONE;
    wire [1:0] rearm_req = ready;
    wire [7:0] disp_next = !INIT_DONE ? soc_pkg::DISP_INIT :
                           (MUTE_A && MUTE_B) ? soc_pkg::DISP_MUTE_AB :
                           MUTE_A ? soc_pkg::DISP_MUTE_A :
                           MUTE_B ? soc_pkg::DISP_MUTE_B :
                           8'(area_reg) + 8'h01;

    // shared terminals take the function picked in the terminal register
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            safe_a_reg <= 1'b0;
            alert_a_reg <= 1'b0;
            alert_b_reg <= 1'b0;
            multi_a_reg <= 1'b0;
            multi_b_reg <= 1'b0;
            disp_reg <= soc_pkg::DISP_INIT;
        end else begin
            safe_a_reg <= safe_on[0];
            alert_a_reg <= term_reg[soc_pkg::TERM_C_SEL] ? safe_on[1] : alert_a;
            alert_b_reg <= term_reg[soc_pkg::TERM_D_SEL] ? safe_on[1] : alert_b;
            multi_a_reg <= multi_sel(term_reg[soc_pkg::TERM_E_LSB +: 2],
                rearm_req[0], MUTE_A, AUX_A);
            multi_b_reg <= multi_sel(term_reg[soc_pkg::TERM_F_LSB +: 2],
                rearm_req[1], MUTE_B, AUX_B);
            disp_reg <= disp_next;
        end
    end

    assign SAFETY_SWITCH_OUTPUT = safe_a_reg;
    assign TERM_ALERT_A = alert_a_reg;
    assign TERM_ALERT_B = alert_b_reg;
    assign TERM_MULTI_A = multi_a_reg;
    assign TERM_MULTI_B = multi_b_reg;
    assign DISPLAY_CODE = disp_reg;

    // ****************************************
    // register read
    // ****************************************
    wire [31:0] status = {16'h0000, 2'h0, hw_fault_reg, cfg_err, lock_reg, rearm_req,
                          2'h0, safe_on, dly_out_reg};
    wire [31:0] rd_mux = (ADDR == soc_pkg::ADDR_CTRL) ? ctrl_reg :
                         (ADDR == soc_pkg::ADDR_TERM) ? term_reg :
                         (ADDR >= soc_pkg::ADDR_DLY0 && ADDR < soc_pkg::ADDR_STATUS) ?
                             dly_reg[2'(ADDR - soc_pkg::ADDR_DLY0)] :
                         (ADDR == soc_pkg::ADDR_STATUS) ? status :
                         (ADDR == soc_pkg::ADDR_DISP) ? {24'h000000, disp_reg} :
                         (ADDR == soc_pkg::ADDR_SEQ_IDX) ? {27'h0000000, seq_idx_reg} :
                         32'h0000_0000;

    // read data valid only in the cycle after the strobe
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= RD ? rd_mux : 32'h0000_0000;
        end
    end

    assign RDATA = rdata_reg;
endmodule : soc_top

// >>> soc_top_sva.sv
`timescale 1ns/1ps
module soc_chk #(
    parameter int MS_CYC = 20000
) (
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic [3:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic INIT_DONE,
    input wire logic ZONE_A_OBJ,
    input wire logic WARN_A_OBJ,
    input wire logic REF_SHIFT,
    input wire logic ACCESS_PEN,
    input wire logic MUTE_A,
    input wire logic MUTE_B,
    input wire logic SAFETY_SWITCH_OUTPUT,
    input wire logic TERM_ALERT_A,
    input wire logic [7:0] DISPLAY_CODE
);
    localparam int SCAN = MS_CYC * 30;
    localparam int ON_LO = (soc_pkg::ON_MIN_MS / soc_pkg::SCAN_MS - 1) * SCAN - 2;
    localparam int OFF_HI = (soc_pkg::OFF_MAX_MS / soc_pkg::SCAN_MS + 2) * SCAN;
    logic [31:0] ctrl_reg, term_reg, clr_reg, obj_reg, wrn_reg;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    // ****
    // mirrored control words and persistence counters
    // ****
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            ctrl_reg <= '0;
            term_reg <= '0;
            clr_reg <= '0;
            obj_reg <= '0;
            wrn_reg <= '0;
        end else begin
            if (WR && ADDR == soc_pkg::ADDR_CTRL) ctrl_reg <= WDATA;
            if (WR && ADDR == soc_pkg::ADDR_TERM) term_reg <= WDATA;
            clr_reg <= ZONE_A_OBJ ? '0 : clr_reg + 1;
            obj_reg <= !(ZONE_A_OBJ && !MUTE_A) ? '0 : obj_reg + 32'(obj_reg < OFF_HI);
            wrn_reg <= !(WARN_A_OBJ && !term_reg[0]) ? '0 : wrn_reg + 32'(wrn_reg < OFF_HI);
        end
    end
    // muting display codes follow the zone states one cycle later
    a_mute_a_code: assert property (
        INIT_DONE && MUTE_A && !MUTE_B |=> DISPLAY_CODE == soc_pkg::DISP_MUTE_A)
        else $error("display code wrong for zone A muting");
    a_mute_b_code: assert property (
        INIT_DONE && !MUTE_A && MUTE_B |=> DISPLAY_CODE == soc_pkg::DISP_MUTE_B)
        else $error("display code wrong for zone B muting");
    a_mute_ab_code: assert property (
        INIT_DONE && MUTE_A && MUTE_B |=> DISPLAY_CODE == soc_pkg::DISP_MUTE_AB)
        else $error("display code wrong for both zones muted");
    // fault events drop the output and keep it off for eight cycles
    a_ref_drop: assert property (
        REF_SHIFT && ctrl_reg[0] |=> !SAFETY_SWITCH_OUTPUT [*8])
        else $error("output not dropped after reference shift");
    a_access_drop: assert property (
        ACCESS_PEN && ctrl_reg[1] |=> !SAFETY_SWITCH_OUTPUT [*8])
        else $error("output not dropped after access penetration");
    // switching on needs the zone clear for at least the minimum on delay less one scan
    a_on_persist: assert property (
        $rose(SAFETY_SWITCH_OUTPUT) |-> clr_reg >= 32'(ON_LO))
        else $error("output switched on too early");
    a_off_bound: assert property (
        obj_reg == 32'(OFF_HI) |-> !SAFETY_SWITCH_OUTPUT)
        else $error("output still on past the longest off delay");
    a_alert_off: assert property (
        wrn_reg == 32'(OFF_HI) |-> !TERM_ALERT_A)
        else $error("warning output still on with obstacle present");
endmodule : soc_chk

bind soc_top soc_chk #(.MS_CYC(MS_CYC)) u_chk (.*);

// >>> soc_ctrl_model.sv
`timescale 1ns/1ps
module soc_ctrl_model #(
    parameter int MS_CYC = 4
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic go,
    input wire logic [15:0] hold_ms,
    input wire logic rearm_req,
    output logic reset_in
);
    logic [31:0] cnt_reg;
    // presses reset only when asked, never up to the malfunction limit
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= '0;
        end else if (go && rearm_req) begin
            cnt_reg <= (hold_ms > 16'h752F ? 32'h752F : 32'(hold_ms)) * MS_CYC;
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1;
        end
    end
    assign reset_in = cnt_reg != '0;
endmodule : soc_ctrl_model

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam int MS = 4;
    localparam int SCAN = MS * 30;
    logic clk, rst_b, wr, rd, init, zobj, wobj, refs, accp, mua, mub, go, ps, rd_d;
    logic rst_in, sso, ala, alb, mla, mlb;
    logic [3:0] addr;
    logic [4:0] area, ar;
    logic [7:0] disp;
    logic [15:0] hold;
    logic [31:0] wdata, rdata;
    logic [31:0] eq[$], mq[$];
    logic [31:0] ctl[3] = '{32'h0, 32'h20, 32'h40};
    int on_s[3] = '{10, 10, 9};
    int off_s[3] = '{4, 2, 2};
    int n_mismatch = 0;
    int n_tests = 0;
    soc_top #(.MS_CYC(MS)) dut (.CLK_SYS(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .INIT_DONE(init), .ZONE_A_OBJ(zobj),
        .ZONE_B_OBJ(1'b0), .WARN_A_OBJ(wobj), .WARN_B_OBJ(wobj), .REF_SHIFT(refs),
        .ACCESS_PEN(accp), .AREA_SEL(area), .MUTE_A(mua), .MUTE_B(mub), .AUX_A(1'b0),
        .AUX_B(mub), .RESET_IN(rst_in), .SAFETY_SWITCH_OUTPUT(sso), .TERM_ALERT_A(ala),
        .TERM_ALERT_B(alb), .TERM_MULTI_A(mla), .TERM_MULTI_B(mlb), .DISPLAY_CODE(disp));
    soc_ctrl_model #(.MS_CYC(MS)) ctrl (.clk(clk), .rst_b(rst_b), .go(go), .hold_ms(hold),
        .rearm_req(mla), .reset_in(rst_in));
    // ****
    // bus, wait and compare helpers
    // ****
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic wrr(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        cyc(1);
        wr <= 1'b0;
        cyc(1);
    endtask : wrr
    task automatic rchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        eq.push_back(e);
        mq.push_back(m);
        addr <= a;
        rd <= 1'b1;
        cyc(1);
        rd <= 1'b0;
        cyc(1);
    endtask : rchk
    task automatic pchk(input logic [31:0] m, input logic [31:0] e);
        eq.push_back(e);
        mq.push_back(m);
        ps <= 1'b1;
        cyc(1);
        ps <= 1'b0;
        cyc(1);
    endtask : pchk
    task automatic press(input logic [15:0] h);
        hold <= h;
        go <= 1'b1;
        cyc(1);
        go <= 1'b0;
        cyc(int'(h) * MS + 11 * SCAN);
    endtask : press
    task automatic cmp(input logic [31:0] v);
        logic [31:0] e, m;
        e = eq.pop_front();
        m = mq.pop_front();
        n_tests++;
        if ((v & m) !== e) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, v & m, e);
        end
    endtask : cmp
    task automatic test_done();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done
    // clock and result watcher: read data one cycle after the strobe, ports on request
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        rd_d <= rd;
        if (rd_d || ps) cmp(rd_d ? rdata : {19'h0, disp, mlb, mla, alb, ala, sso});
    end
    initial begin
        cyc(60000);
        n_mismatch++;
        test_done();
    end
    // main sequence
    initial begin
        {rst_b, wr, rd, init, wobj, refs, accp, mua, mub, go, ps} = '0;
        zobj = 1'b1;
        addr = '0;
        area = '0;
        hold = '0;
        wdata = '0;
        void'($urandom(32'h205F184F));
        cyc(16);
        rst_b <= 1'b1;
        cyc(1);
        rchk(soc_pkg::ADDR_CTRL, '1, soc_pkg::CTRL_RST);
        rchk(soc_pkg::ADDR_DLY0, '1, soc_pkg::DLY_RST);
        wrr(4'hA, 32'hFFFF_FFFF);
        rchk(4'hA, '1, 32'h0);
        pchk(32'h1FE0, 32'h0);
        $display("register test done");
        init <= 1'b1;
        wobj <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            wrr(soc_pkg::ADDR_DLY0, 32'h0000_0901);
            wrr(soc_pkg::ADDR_CTRL, ctl[i]);
            zobj <= 1'b0;
            cyc((on_s[i] - 1) * SCAN - 8);
            pchk(32'h1, 32'h0);
            cyc(2 * SCAN);
            pchk(32'h1, 32'h1);
            zobj <= 1'b1;
            cyc((off_s[i] - 1) * SCAN - 8);
            pchk(32'h1, 32'h1);
            cyc(2 * SCAN);
            pchk(32'h7, 32'h0);
        end
        $display("delay test done");
        wrr(soc_pkg::ADDR_TERM, 32'h27);
        for (int m = 0; m < 4; m++) begin
            ar = 5'($urandom);
            area <= ar;
            {mub, mua} <= 2'(m);
            cyc(4);
            pchk(32'h1FFE, {19'h0, m == 0 ? 8'(ar) + 8'h01 : 8'(8'h24 + m),
                2'(m), 2'h3, 1'h0});
        end
        {mub, mua} <= 2'h0;
        wrr(soc_pkg::ADDR_TERM, 32'h0);
        $display("muting test done");
        zobj <= 1'b0;
        wrr(soc_pkg::ADDR_CTRL, 32'h43);
        for (int j = 0; j < 2; j++) begin
            cyc(11 * SCAN);
            pchk(32'h9, 32'h1);
            refs <= (j == 0);
            accp <= (j == 1);
            cyc(1);
            refs <= 1'b0;
            accp <= 1'b0;
            cyc(20);
            pchk(32'h9, 32'h8);
            rchk(soc_pkg::ADDR_STATUS, 32'h100, 32'h100);
            if (j == 0) begin
                press(16'h0190);
                pchk(32'h1, 32'h0);
            end
            press(16'h0258);
            pchk(32'h9, 32'h1);
        end
        $display("fault test done");
        wrr(soc_pkg::ADDR_CTRL, 32'h40);
        area <= 5'h05;
        cyc(4);
        pchk(32'h1, 32'h1);
        // area 5 may go to 6, area 6 only to 0, area 7 has no successor
        for (int k = 5; k < 8; k++) begin
            wrr(soc_pkg::ADDR_SEQ_IDX, 32'(k));
            wrr(soc_pkg::ADDR_SEQ_DATA, (32'(k == 5) << 6) | 32'(k == 6));
        end
        wrr(soc_pkg::ADDR_CTRL, 32'h44);
        area <= 5'h06;
        cyc(4);
        pchk(32'h1, 32'h1);
        rchk(soc_pkg::ADDR_STATUS, 32'h1000, 32'h0);
        area <= 5'h07;
        cyc(4);
        pchk(32'h1, 32'h0);
        rchk(soc_pkg::ADDR_STATUS, 32'h1000, 32'h1000);
        zobj <= 1'b1;
        cyc(70 * SCAN);
        pchk(32'h1, 32'h0);
        $display("sequence test done");
        test_done();
    end
endmodule : tb_top
